// *** src/trig_regs.vh ***
`ifndef TRIG_REGS_VH
`define TRIG_REGS_VH

// register byte offsets
`define REG_CTRL        8'h00
`define REG_PERIOD      8'h04
`define REG_WIDTH0      8'h08
`define REG_OFFSET1     8'h0c
`define REG_WIDTH1      8'h10
`define REG_SWTRIG      8'h14
`define REG_STATUS      8'h18
`define REG_STAMP       8'h1c
`define REG_TIME        8'h20
`define REG_LIST_BASE   8'h40

// control fields
`define CTRL_EN0        0
`define CTRL_EN1        1
`define CTRL_IDLE0      2
`define CTRL_IDLE1      3
`define CTRL_POL0       4
`define CTRL_POL1       5
`define CTRL_CYCLE      6
`define CTRL_SWMODE     7
`define CTRL_STAMP_EN   8
`define CTRL_LEN_LSB    12
`define CTRL_LEN_MSB    14
`define CTRL_RESET      32'h0000_0000

// clock and timing
`define CLK_HZ          25000000
`define CLKS_PER_MS     (`CLK_HZ / 1000)
`define FREQ_MIN_MHZ    100
`define FREQ_MAX_HZ     200
`define PERIOD_MAX      32'd250000000
`define PERIOD_MIN      32'd125000
`define PERIOD_RESET    32'd781250
`define WIDTH_RESET     16'h0001
`define LIST_DEPTH      8

`endif

// *** src/pulse_channel.v ***
`timescale 1ns/1ns
// one pulse channel: delayed start then a width counted in ms
module pulse_channel (
    input  wire        i_clock,
    input  wire        i_rst_n,
    input  wire        i_start,
    input  wire [31:0] i_delay,
    input  wire [15:0] i_width_ms,
    input  wire        i_polarity,
    input  wire        i_enable,
    input  wire        i_idle_level,
    output reg         o_pulse
);
`include "trig_regs.vh"

    localparam [31:0] CLKS_MS = `CLKS_PER_MS;

    reg        wait_ff;
    reg        active_ff;
    reg [31:0] dcnt_ff;
    reg [15:0] mcnt_ff;
    reg [31:0] tick_ff;

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_ff   <= 1'b0;
            active_ff <= 1'b0;
            dcnt_ff   <= 32'h0000_0000;
            mcnt_ff   <= 16'h0000;
            tick_ff   <= 32'h0000_0000;
            o_pulse   <= 1'b0;
        end else begin
            if (!i_enable) begin
                wait_ff   <= 1'b0;
                active_ff <= 1'b0;
            end else if (i_start) begin
                // start restarts any pulse still in flight
                wait_ff   <= (i_delay != 32'h0000_0000);
                active_ff <= (i_delay == 32'h0000_0000) && (i_width_ms != 16'h0000);
                dcnt_ff   <= i_delay;
                mcnt_ff   <= i_width_ms;
                tick_ff   <= 32'h0000_0000;
            end else if (wait_ff) begin
                dcnt_ff <= dcnt_ff - 32'h0000_0001;
                if (dcnt_ff == 32'h0000_0001) begin
                    wait_ff   <= 1'b0;
                    active_ff <= (mcnt_ff != 16'h0000);
                end
            end else if (active_ff) begin
                if (tick_ff == CLKS_MS - 32'h0000_0001) begin
                    tick_ff <= 32'h0000_0000;
                    mcnt_ff <= mcnt_ff - 16'h0001;
                    if (mcnt_ff == 16'h0001) begin
                        active_ff <= 1'b0;
                    end
                end else begin
                    tick_ff <= tick_ff + 32'h0000_0001;
                end
            end
            // disabled output holds its constant level
            if (!i_enable) begin
                o_pulse <= i_idle_level;
            end else begin
                o_pulse <= i_polarity ? ~active_ff : active_ff;
            end
        end
    end
endmodule

// *** src/trigger_gen.v ***
`timescale 1ns/1ns
module trigger_gen (
    input  wire        i_clock,
    input  wire        i_rst_n,
    input  wire        i_hsel,
    input  wire [31:0] i_haddr,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [2:0]  i_hsize,
    input  wire [31:0] i_hwdata,
    input  wire        i_hready,
    output reg  [31:0] o_hrdata,
    output wire        o_hreadyout,
    output wire        o_hresp,
    output wire        o_trigger0,
    output wire        o_trigger1,
    output reg         o_frame_stamp_valid,
    output reg  [31:0] o_frame_stamp
);
`include "trig_regs.vh"

    localparam [31:0] PMAX = `PERIOD_MAX;
    localparam [31:0] PMIN = `PERIOD_MIN;

    // software registers
    reg [31:0] ctrl_ff;
    reg [31:0] period_ff;
    reg [15:0] width0_ff;
    reg [31:0] offset1_ff;
    reg [15:0] width1_ff;
    reg [15:0] list_ff [0:`LIST_DEPTH-1];
    reg        swreq_ff;
    reg        stamp_sticky_ff;

    // shadow copies taken at the period boundary
    reg [15:0] sh_width0_ff;
    reg [31:0] sh_offset1_ff;
    reg [15:0] sh_width1_ff;
    reg        sh_pol0_ff;
    reg        sh_pol1_ff;

    reg [31:0] pcnt_ff;
    reg [2:0]  lidx_ff;
    reg [31:0] time_ff;
    reg [31:0] stamp_ff;
    reg [31:0] pulse_count_ff;
    reg        en0_q_ff;
    reg        en1_q_ff;

    // ahb data phase state
    reg        dwr_ff;
    reg        drd_ff;
    reg [7:0]  daddr_ff;

    wire       en0      = ctrl_ff[`CTRL_EN0];
    wire       en1      = ctrl_ff[`CTRL_EN1] & en0;
    wire       sw_mode  = ctrl_ff[`CTRL_SWMODE];
    wire       cyc_mode = ctrl_ff[`CTRL_CYCLE];
    wire [2:0] list_len = ctrl_ff[`CTRL_LEN_MSB:`CTRL_LEN_LSB];

    function [31:0] clamp_period;
        input [31:0] p;
        begin
            if (p > PMAX) begin
                clamp_period = PMAX;
            end else if (p < PMIN) begin
                clamp_period = PMIN;
            end else begin
                clamp_period = p;
            end
        end
    endfunction

    function is_list_addr;
        input [7:0] a;
        begin
            is_list_addr = (a >= `REG_LIST_BASE) && (a < `REG_LIST_BASE + 8'h20);
        end
    endfunction

    // ahb-lite slave, zero wait states
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    wire take = i_hsel & i_hready & i_htrans[1];

    // period boundary: timer wrap in periodic mode, command in software mode
    wire timer_wrap = en0 & ~sw_mode & (pcnt_ff == 32'h0000_0000);
    wire sw_fire    = en0 & sw_mode & swreq_ff;
    wire fire       = timer_wrap | sw_fire;

    wire [15:0] cur_width0 = cyc_mode ? list_ff[lidx_ff] : sh_width0_ff;

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dwr_ff   <= 1'b0;
            drd_ff   <= 1'b0;
            daddr_ff <= 8'h00;
        end else begin
            dwr_ff   <= take & i_hwrite;
            drd_ff   <= take & ~i_hwrite;
            daddr_ff <= i_haddr[7:0];
        end
    end

    integer k;
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_ff    <= `CTRL_RESET;
            period_ff  <= `PERIOD_RESET;
            width0_ff  <= `WIDTH_RESET;
            offset1_ff <= 32'h0000_0000;
            width1_ff  <= `WIDTH_RESET;
            swreq_ff   <= 1'b0;
            for (k = 0; k < `LIST_DEPTH; k = k + 1) begin
                list_ff[k] <= `WIDTH_RESET;
            end
        end else begin
            // software request consumed by a fire; a new write wins
            if (sw_fire) begin
                swreq_ff <= 1'b0;
            end
            if (dwr_ff) begin
                case (daddr_ff)
                    `REG_CTRL:    ctrl_ff    <= i_hwdata;
                    // clamped on write, so software reads back what runs
                    `REG_PERIOD:  period_ff  <= clamp_period(i_hwdata);
                    `REG_WIDTH0:  width0_ff  <= i_hwdata[15:0];
                    `REG_OFFSET1: offset1_ff <= i_hwdata;
                    `REG_WIDTH1:  width1_ff  <= i_hwdata[15:0];
                    `REG_SWTRIG: begin
                        if (i_hwdata[0]) begin
                            swreq_ff <= 1'b1;
                        end
                    end
                    default: begin
                        if (is_list_addr(daddr_ff)) begin
                            list_ff[daddr_ff[4:2]] <= i_hwdata[15:0];
                        end
                    end
                endcase
            end
        end
    end

    always @* begin
        o_hrdata = 32'h0000_0000;
        if (drd_ff) begin
            case (daddr_ff)
                `REG_CTRL:    o_hrdata = ctrl_ff;
                `REG_PERIOD:  o_hrdata = period_ff;
                `REG_WIDTH0:  o_hrdata = {16'h0000, width0_ff};
                `REG_OFFSET1: o_hrdata = offset1_ff;
                `REG_WIDTH1:  o_hrdata = {16'h0000, width1_ff};
                `REG_STATUS:  o_hrdata = {pulse_count_ff[23:0], 1'b0, lidx_ff, 2'b00, stamp_sticky_ff, swreq_ff};
                `REG_STAMP:   o_hrdata = stamp_ff;
                `REG_TIME:    o_hrdata = time_ff;
                default: begin
                    if (is_list_addr(daddr_ff)) begin
                        o_hrdata = {16'h0000, list_ff[daddr_ff[4:2]]};
                    end
                end
            endcase
        end
    end

    // period timer and shadow update
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pcnt_ff        <= 32'h0000_0000;
            lidx_ff        <= 3'h0;
            en0_q_ff       <= 1'b0;
            en1_q_ff       <= 1'b0;
            sh_width0_ff   <= `WIDTH_RESET;
            sh_offset1_ff  <= 32'h0000_0000;
            sh_width1_ff   <= `WIDTH_RESET;
            sh_pol0_ff     <= 1'b0;
            sh_pol1_ff     <= 1'b0;
            pulse_count_ff <= 32'h0000_0000;
        end else begin
            if (!en0) begin
                pcnt_ff <= 32'h0000_0000;
                lidx_ff <= 3'h0;
            end else if (fire) begin
                // new widths and offset only take effect here; polarity also when a channel switches on
                sh_width0_ff   <= width0_ff;
                sh_offset1_ff  <= offset1_ff;
                sh_width1_ff   <= width1_ff;
                sh_pol0_ff     <= ctrl_ff[`CTRL_POL0];
                sh_pol1_ff     <= ctrl_ff[`CTRL_POL1];
                pcnt_ff        <= clamp_period(period_ff) - 32'h0000_0001;
                pulse_count_ff <= pulse_count_ff + 32'h0000_0001;
                if (cyc_mode) begin
                    lidx_ff <= (lidx_ff >= list_len) ? 3'h0 : lidx_ff + 3'h1;
                end
            end else if (!sw_mode) begin
                pcnt_ff <= pcnt_ff - 32'h0000_0001;
            end
            en0_q_ff <= en0;
            en1_q_ff <= en1;
            // a channel just switched on takes its polarity at once, else a stale one fakes an edge
            if (!en0_q_ff) begin
                sh_pol0_ff <= ctrl_ff[`CTRL_POL0];
            end
            if (!en1_q_ff) begin
                sh_pol1_ff <= ctrl_ff[`CTRL_POL1];
            end
        end
    end

    // free running time base, stamp captured at each fire while CTRL_STAMP_EN is set
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            time_ff             <= 32'h0000_0000;
            stamp_ff            <= 32'h0000_0000;
            stamp_sticky_ff     <= 1'b0;
            o_frame_stamp       <= 32'h0000_0000;
            o_frame_stamp_valid <= 1'b0;
        end else begin
            time_ff             <= time_ff + 32'h0000_0001;
            o_frame_stamp_valid <= 1'b0;
            if (fire & ctrl_ff[`CTRL_STAMP_EN]) begin
                // relies on cameras answering every trigger
                stamp_ff            <= time_ff;
                o_frame_stamp       <= time_ff;
                o_frame_stamp_valid <= 1'b1;
                stamp_sticky_ff     <= 1'b1;
            end else if (drd_ff && daddr_ff == `REG_STAMP) begin
                stamp_sticky_ff <= 1'b0;
            end
        end
    end

    // widths and polarity taken straight from the new values on a fire
    wire [15:0] w0_now  = fire ? (cyc_mode ? list_ff[lidx_ff] : width0_ff) : cur_width0;
    wire        p0_now  = (fire | ~en0_q_ff) ? ctrl_ff[`CTRL_POL0] : sh_pol0_ff;
    wire        p1_now  = (fire | ~en1_q_ff) ? ctrl_ff[`CTRL_POL1] : sh_pol1_ff;
    wire [15:0] w1_now  = fire ? width1_ff : sh_width1_ff;
    wire [31:0] d1_now  = fire ? offset1_ff : sh_offset1_ff;

    pulse_channel u_primary (
        .i_clock      (i_clock),
        .i_rst_n      (i_rst_n),
        .i_start      (fire),
        .i_delay      (32'h0000_0000),
        .i_width_ms   (w0_now),
        .i_polarity   (p0_now),
        .i_enable     (en0),
        .i_idle_level (ctrl_ff[`CTRL_IDLE0]),
        .o_pulse      (o_trigger0)
    );

    // same start as primary, so same frequency
    pulse_channel u_secondary (
        .i_clock      (i_clock),
        .i_rst_n      (i_rst_n),
        .i_start      (fire & en1),
        .i_delay      (d1_now),
        .i_width_ms   (w1_now),
        .i_polarity   (p1_now),
        .i_enable     (en1),
        .i_idle_level (ctrl_ff[`CTRL_IDLE1]),
        .o_pulse      (o_trigger1)
    );

endmodule

// *** bench/camera_model.sv ***
`timescale 1ns/1ns
// one camera: counts pulses, times the width and the leading edge
module camera_model (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_trigger,
    input  wire logic        i_active_low,
    output logic      [31:0] o_count,
    output logic      [31:0] o_width,
    output logic      [31:0] o_edge_time
);
    logic [31:0] now_ff;
    logic [31:0] run_ff;
    logic        prev_ff;
    wire         act = i_trigger ^ i_active_low;
    // answers every pulse, none skipped
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            now_ff      <= 32'h0;
            run_ff      <= 32'h0;
            prev_ff     <= 1'b1;
            o_count     <= 32'h0;
            o_width     <= 32'h0;
            o_edge_time <= 32'h0;
        end else begin
            now_ff  <= now_ff + 32'h1;
            prev_ff <= act;
            run_ff  <= act ? run_ff + 32'h1 : 32'h0;
            if (act && !prev_ff) begin
                o_count     <= o_count + 32'h1;
                o_edge_time <= now_ff;
            end
            if (!act && prev_ff) begin
                o_width <= run_ff;
            end
        end
    end
endmodule

// *** bench/trigger_gen_assertions.sv ***
`timescale 1ns/1ns
`include "trig_regs.vh"
module trigger_gen_assertions (
    input wire        i_clock,
    input wire        i_rst_n,
    input wire        i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0]  i_htrans,
    input wire        i_hwrite,
    input wire [31:0] i_hwdata,
    input wire        i_hready,
    input wire        o_trigger0,
    input wire        o_trigger1,
    input wire        o_frame_stamp_valid,
    input wire [31:0] o_frame_stamp
);
    logic        dwr_ff;
    logic [7:0]  dadr_ff;
    logic [31:0] ctrl_ff;
    // shadow of the control word, taken from bus writes
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dwr_ff  <= 1'b0;
            dadr_ff <= 8'h00;
            ctrl_ff <= `CTRL_RESET;
        end else begin
            dwr_ff  <= i_hsel & i_hready & i_htrans[1] & i_hwrite;
            dadr_ff <= i_haddr[7:0];
            if (dwr_ff && dadr_ff == `REG_CTRL) begin
                ctrl_ff <= i_hwdata;
            end
        end
    end
    wire sw_wr = dwr_ff && dadr_ff == `REG_SWTRIG && i_hwdata[0];
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    property p_rst; $rose(i_rst_n) |-> !o_trigger0 && !o_trigger1; endproperty
    a_rst: assert property (p_rst) else $error("trigger active after reset");
    property p_idle0; !ctrl_ff[0] && $stable(ctrl_ff) |-> o_trigger0 == ctrl_ff[2]; endproperty
    a_idle0: assert property (p_idle0) else $error("primary not at idle level");
    property p_idle1; (!ctrl_ff[0] || !ctrl_ff[1]) && $stable(ctrl_ff) |-> o_trigger1 == ctrl_ff[3]; endproperty
    a_idle1: assert property (p_idle1) else $error("secondary not at idle level");
    property p_off; $fell(ctrl_ff[0]) |=> o_trigger0 == ctrl_ff[2]; endproperty
    a_off: assert property (p_off) else $error("primary slow to disable");
    property p_fire; sw_wr && ctrl_ff[0] && ctrl_ff[7] && ctrl_ff[8] |-> ##[1:4] o_frame_stamp_valid; endproperty
    a_fire: assert property (p_fire) else $error("no stamp after software fire");
    property p_quiet; (ctrl_ff[0] && ctrl_ff[7] && !sw_wr && $stable(ctrl_ff))[*4] |=> !o_frame_stamp_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("stamp without command");
    property p_pulse; o_frame_stamp_valid |=> !o_frame_stamp_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("stamp valid too long");
    property p_new; $changed(o_frame_stamp) |-> o_frame_stamp_valid; endproperty
    a_new: assert property (p_new) else $error("stamp moved without valid");
    c_fire: cover property (sw_wr && ctrl_ff[7]);
    c_sec: cover property ($fell(o_trigger1) && ctrl_ff[1]);
    c_stamp: cover property (o_frame_stamp_valid);
endmodule
bind trigger_gen trigger_gen_assertions i_trigger_gen_assertions (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .o_trigger0(o_trigger0), .o_trigger1(o_trigger1),
    .o_frame_stamp_valid(o_frame_stamp_valid), .o_frame_stamp(o_frame_stamp));

// *** bench/testbench.sv ***
`timescale 1ns/1ns
`include "trig_regs.vh"
module testbench;
    logic        i_clock;
    logic        i_rst_n;
    logic        hsel;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] rd_q;
    wire  [31:0] hrdata;
    wire  [31:0] stamp;
    wire         rdy;
    wire         trig0;
    wire         trig1;
    wire  [31:0] cnt0, wid0, edge0, cnt1, wid1, edge1;
    int          errors;
    int          n_checks;
    trigger_gen i_trigger_gen (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(rdy),
        .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(), .o_trigger0(trig0), .o_trigger1(trig1),
        .o_frame_stamp_valid(), .o_frame_stamp(stamp));
    camera_model i_camera_model0 (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_trigger(trig0),
        .i_active_low(1'b0), .o_count(cnt0), .o_width(wid0), .o_edge_time(edge0));
    camera_model i_camera_model1 (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_trigger(trig1),
        .i_active_low(1'b1), .o_count(cnt1), .o_width(wid1), .o_edge_time(edge1));
    // read data taken at the data-phase edge, before that edge's updates
    always @(posedge i_clock) rd_q <= hrdata;
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge i_clock);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        do @(posedge i_clock); while (rdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge i_clock); while (rdy !== 1'b1);
        #1 q = rd_q;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task wait_clk(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task t_reset;
        chk({30'h0, trig1, trig0}, 32'h0);
        rd_chk(`REG_CTRL, `CTRL_RESET);
        rd_chk(`REG_PERIOD, `PERIOD_RESET);
        rd_chk(`REG_WIDTH0, {16'h0, `WIDTH_RESET});
        wr(8'h30, 32'hffff_ffff);
        rd_chk(8'h30, 32'h0);
    endtask
    task t_idle;
        wr(`REG_CTRL, 32'h0000_000e);
        wait_clk(3);
        chk({30'h0, trig1, trig0}, 32'h3);
        wr(`REG_CTRL, 32'h0000_0008);
        wait_clk(3);
        chk({30'h0, trig1, trig0}, 32'h2);
    endtask
    task t_period;
        wr(`REG_PERIOD, 32'd100);
        rd_chk(`REG_PERIOD, `PERIOD_MIN);
        wr(`REG_PERIOD, 32'hffff_ffff);
        rd_chk(`REG_PERIOD, `PERIOD_MAX);
        wr(`REG_CTRL, 32'h0000_0009);
        wait_clk(3);
        chk({31'h0, trig0}, 32'h1);
        wr(`REG_CTRL, 32'h0000_0008);
        wait_clk(3);
        chk({31'h0, trig0}, 32'h0);
    endtask
    task t_sw_pulse;
        logic [31:0] c0;
        logic [31:0] c1;
        logic [31:0] q;
        c0 = cnt0;
        c1 = cnt1;
        wr(`REG_WIDTH0, 32'h1);
        wr(`REG_WIDTH1, 32'h1);
        wr(`REG_OFFSET1, 32'd100);
        wr(`REG_CTRL, 32'h0000_01ab);
        wr(`REG_SWTRIG, 32'h1);
        wait_clk(200);
        // a width change in flight must not stretch this pulse
        wr(`REG_WIDTH0, 32'h2);
        wait_clk(25200);
        chk(cnt0 - c0, 32'h1);
        chk(cnt1 - c1, 32'h1);
        chk(wid0, `CLKS_PER_MS);
        chk(wid1, `CLKS_PER_MS);
        chk(edge1 - edge0, 32'd100);
        chk(edge0 - stamp, 32'h2);
        bus(1'b0, `REG_STATUS, 32'h0, q);
        chk(q & 32'h2, 32'h2);
    endtask
    task t_list;
        logic [31:0] q;
        wr(`REG_LIST_BASE, 32'h1);
        wr(`REG_LIST_BASE + 8'h04, 32'h1);
        wr(`REG_CTRL, 32'h0000_10c9);
        for (int i = 1; i <= 3; i++) begin
            wr(`REG_SWTRIG, 32'h1);
            wait_clk(3);
            bus(1'b0, `REG_STATUS, 32'h0, q);
            chk((q >> 4) & 32'h7, 32'(i % 2));
        end
        // reset in mid-run with the list index away from its first entry
        @(posedge i_clock);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_rst_n <= 1'b1;
        wait_clk(1);
        chk({30'h0, trig1, trig0}, 32'h0);
        bus(1'b0, `REG_STATUS, 32'h0, q);
        chk((q >> 4) & 32'h7, 32'h0);
        wr(`REG_CTRL, 32'h0000_0008);
        bus(1'b0, `REG_STATUS, 32'h0, q);
        chk((q >> 4) & 32'h7, 32'h0);
    endtask
    task summarize;
        if (errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        errors = 0;
        n_checks = 0;
        i_rst_n = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (3) @(posedge i_clock);
        i_rst_n <= 1'b1;
        wait_clk(1);
        t_reset;
        t_idle;
        t_period;
        t_sw_pulse;
        t_list;
        summarize;
    end
    // whole run needs about 25500 cycles
    initial begin
        repeat (60000) @(posedge i_clock);
        errors++;
        summarize;
    end
endmodule
